// ==== src/modulo_counter_capture_compare_core.sv ====
// four-channel modulo counter core with apb register access
// Function
// - counter halts while debug break active
// - break clear enable lets clears stick
// - without it, break accesses keep status, except a dma low byte access still clears a channel flag
// - select 111 counts external clock pin
// - external pin forced input while selected
// - four channels; buffered on 0, 2
// - overflow clears by read then write 0
// - overflow irq when flag and enable
// - halt bit stops counter, set by reset
// - clear bit zeroes counter and prescaler
// - halt plus clear stops at zero
// - select 000..110 divides by 1..64
// - route bit picks dma or cpu
// - high byte read latches low byte
// - match with period flags and wraps
// - high period write inhibits overflow flag
// - channel control byte bit layout
// - channel flag set, dma access clears
// - mode and edge bits decoding
`timescale 1ns/100ps
`default_nettype none
module modulo_counter_capture_compare_core
    import mcc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        debugBreak,       // debug break state
    input  wire logic        breakClearEnable, // clears allowed in break
    input  wire logic        extCountClock,    // external count clock pin
    output logic             extClockInUse,    // pin held as input
    input  wire logic [3:0]  chanPinIn,
    output logic [3:0]       chanPinOut,
    output logic [3:0]       chanPinOeN,
    output logic             overflowIrq,
    output logic [3:0]       chanIrq,
    output logic [3:0]       chanDmaReq
);
`include "mcc_consts.svh"
    core_state_t s;          // all state
    core_state_t next_s;     // next state
    logic        access;     // apb access phase
    logic        wr;         // write taken this cycle
    logic        rd;         // read taken this cycle
    logic [7:0]  idx;        // register index
    logic        aligned;    // address well formed
    logic [7:0]  wbyte;      // written byte
    logic        statusOk;   // status bits may change
    logic        run;        // counter may advance
    logic        clearWr;    // counter clear written
    logic        tick;       // counter enable from prescaler
    logic        ovf;        // overflow event this cycle
    logic [3:0]  chEvt;      // channel events
    logic [3:0]  chEn;       // channel not taken by its partner
    logic [3:0]  match;      // compare match per channel
    logic        hit;        // mapped register
    logic [7:0]  rbyte;      // read byte

    // control register index of a channel
    function automatic logic [7:0] ctrlIdx(input int i);
        ctrlIdx = 8'(`IDX_CH0_CTRL + 3 * i);
    endfunction

    // value high byte index of a channel
    function automatic logic [7:0] valIdx(input int i);
        valIdx = 8'(`IDX_CH0_HI + 3 * i);
    endfunction

    // apb decode; every access finishes with no wait state
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign idx = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign statusOk = !debugBreak || breakClearEnable;
    assign run = !s.halt && !debugBreak;
    assign clearWr = wr && aligned && idx == `IDX_STATUS && wbyte[`ST_CLEAR];
    assign extClockInUse = (s.divSel == `SEL_EXTERNAL);
    assign chEn = {!s.chCtrl[2][`CH_BUF], 1'b1, !s.chCtrl[0][`CH_BUF], 1'b1};

    // prescaler and external clock qualifier
    count_prescaler u_presc (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (run),
        .clear   (clearWr),
        .divSel  (s.divSel),
        .extPin  (extCountClock),
        .tick    (tick)
    );

    // the four channels
    for (genvar g = 0; g < 4; g++) begin : g_chan
        assign match[g] = s.step && (s.count == s.chVal[g]);
        capture_compare_channel u_chan (
            .sys_clk (sys_clk),
            .reset   (reset),
            .ctrl    (s.chCtrl[g]),
            .enable  (chEn[g]),
            .match   (match[g]),
            .wrap    (s.wrapped),
            .hold    (s.chHiRead[g]),
            .pinIn   (chanPinIn[g]),
            .event_  (chEvt[g]),
            .pinOut  (chanPinOut[g]),
            .pinOeN  (chanPinOeN[g])
        );
    end

    // read data mux; unmapped or misaligned answers with an error
    always_comb begin
        hit = aligned;
        rbyte = 8'h00;
        case (idx)
            `IDX_STATUS: rbyte = {s.overflow_flag, s.overflow_irq_enable, s.halt, 2'b00, s.divSel};
            `IDX_ROUTE:  rbyte = {4'h0, s.route};
            `IDX_CNT_HI: rbyte = s.count[15:8];
            `IDX_CNT_LO: rbyte = s.latched ? s.lowLatch : s.count[7:0];
            `IDX_PER_HI: rbyte = s.period[15:8];
            `IDX_PER_LO: rbyte = s.period[7:0];
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < 4; i++) begin
            if (idx == ctrlIdx(i)) begin
                hit = aligned;
                rbyte = s.chCtrl[i];
            end
            if (idx == valIdx(i)) begin
                hit = aligned;
                rbyte = s.chVal[i][15:8];
            end
            if (idx == valIdx(i) + 8'h01) begin
                hit = aligned;
                rbyte = s.chVal[i][7:0];
            end
        end
        prdata = hit ? {24'h000000, rbyte} : 32'h00000000;
        pslverr = access && !hit;
    end

    // next state: counter, then software accesses, then hardware sets
    always_comb begin
        next_s = s;
        next_s.step = 1'b0;
        next_s.wrapped = 1'b0;
        ovf = 1'b0;
        // counter advance
        if (clearWr) begin
            next_s.count = 16'h0000;
        end else if (tick) begin
            next_s.step = 1'b1;
            if (s.count == s.period) begin
                next_s.count = 16'h0000;
                next_s.wrapped = 1'b1;
                ovf = !s.perInhibit;
            end else begin
                next_s.count = s.count + 16'h0001;
            end
        end
        // register writes
        if (wr && aligned) begin
            case (idx)
                `IDX_STATUS: begin
                    next_s.overflow_irq_enable = wbyte[`ST_IRQ_EN];
                    next_s.halt = wbyte[`ST_HALT];
                    next_s.divSel = wbyte[2:0];
                    if (statusOk) begin
                        // second step of the clear; a pre-break read still counts
                        if (s.tofArm && !wbyte[`ST_FLAG]) begin
                            next_s.overflow_flag = 1'b0;
                        end
                        next_s.tofArm = 1'b0;
                    end
                end
                `IDX_ROUTE:  next_s.route = wbyte[3:0];
                `IDX_PER_HI: begin
                    next_s.period[15:8] = wbyte;
                    next_s.perInhibit = 1'b1;
                end
                `IDX_PER_LO: begin
                    next_s.period[7:0] = wbyte;
                    next_s.perInhibit = 1'b0;
                end
                default: ;
            endcase
        end
        // status read arms the overflow clear
        if (rd && aligned && idx == `IDX_STATUS && s.overflow_flag && statusOk) begin
            next_s.tofArm = 1'b1;
        end
        // counter byte latch
        if (rd && aligned && idx == `IDX_CNT_HI && !s.latched) begin
            next_s.lowLatch = s.count[7:0];
            next_s.latched = 1'b1;
        end
        if (rd && aligned && idx == `IDX_CNT_LO) begin
            next_s.latched = 1'b0;
        end
        // channel registers
        for (int i = 0; i < 4; i++) begin
            if (wr && aligned && idx == ctrlIdx(i)) begin
                // mode b exists on channels 0 and 2 only
                next_s.chCtrl[i][6:0] = wbyte[6:0];
                if (i % 2 == 1) begin
                    next_s.chCtrl[i][`CH_BUF] = 1'b0;
                end
                if (statusOk) begin
                    if (s.chArm[i] && !wbyte[`CH_FLAG]) begin
                        next_s.chCtrl[i][`CH_FLAG] = 1'b0;
                    end
                    next_s.chArm[i] = 1'b0;
                end
            end
            if (rd && aligned && idx == ctrlIdx(i) && s.chCtrl[i][`CH_FLAG] && statusOk) begin
                next_s.chArm[i] = 1'b1;
            end
            if (access && aligned && idx == valIdx(i)) begin
                if (pwrite) begin
                    next_s.chVal[i][15:8] = wbyte;
                end else begin
                    next_s.chHiRead[i] = 1'b1;
                end
            end
            if (access && aligned && idx == valIdx(i) + 8'h01) begin
                if (pwrite) begin
                    next_s.chVal[i][7:0] = wbyte;
                end else begin
                    next_s.chHiRead[i] = 1'b0;
                end
                // dma service: touching the low byte clears the flag
                if (s.route[i] && s.chCtrl[i][`CH_IE]) begin
                    next_s.chCtrl[i][`CH_FLAG] = 1'b0;
                end
            end
            // a channel event beats a same-cycle clear
            if (chEvt[i] && !s.chHiRead[i]) begin
                if (s.chCtrl[i][5:4] == 2'b00) begin
                    next_s.chVal[i] = s.count;
                end
                next_s.chCtrl[i][`CH_FLAG] = 1'b1;
                next_s.chArm[i] = 1'b0;
            end
        end
        // overflow set wins over the clear and voids a pending one
        if (ovf) begin
            next_s.overflow_flag = 1'b1;
            next_s.tofArm = 1'b0;
        end
    end

    // request outputs
    always_comb begin
        overflowIrq = s.overflow_flag && s.overflow_irq_enable;
        for (int i = 0; i < 4; i++) begin
            chanIrq[i] = s.chCtrl[i][`CH_FLAG] && s.chCtrl[i][`CH_IE] && !s.route[i];
            chanDmaReq[i] = s.chCtrl[i][`CH_FLAG] && s.chCtrl[i][`CH_IE] && s.route[i];
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.halt <= 1'b1;
            s.period <= `PERIOD_RESET;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_break_freeze;
        debugBreak && !clearWr |=> $stable(s.count);
    endproperty
    a_break_freeze: assert property (p_break_freeze) else $error("count moved in break");
    property p_halt_freeze;
        s.halt && !clearWr |=> $stable(s.count);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("count moved while halted");
    property p_break_keep;
        debugBreak && !breakClearEnable && s.overflow_flag |=> s.overflow_flag;
    endproperty
    a_break_keep: assert property (p_break_keep) else $error("flag lost in break");
    property p_clear_needs_arm;
        wr && aligned && idx == `IDX_STATUS && !s.tofArm && s.overflow_flag |=> s.overflow_flag;
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("flag cleared unarmed");
    property p_irq;
        s.overflow_flag && s.overflow_irq_enable |-> overflowIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("overflow irq missing");
    property p_clear_zero;
        clearWr |=> s.count == 16'h0000;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero");
    property p_halt_clear;
        clearWr && wbyte[`ST_HALT] |=> s.count == 16'h0000 ##1 s.count == 16'h0000;
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("not stopped at zero");
    property p_wrap;
        tick && !clearWr && s.count == s.period && !s.perInhibit |=> s.count == 16'h0000 && s.overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap or flag missing");
    property p_inhibit;
        s.perInhibit && !s.overflow_flag |=> !s.overflow_flag;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("flag set while inhibited");
    property p_route;
        (chanIrq & chanDmaReq) == 4'h0;
    endproperty
    a_route: assert property (p_route) else $error("both request paths");
    property p_latch;
        rd && aligned && idx == `IDX_CNT_HI |=> s.latched;
    endproperty
    a_latch: assert property (p_latch) else $error("low byte not latched");

    c_wrap: cover property (s.wrapped);
    c_capture: cover property (chEvt[0] && s.chCtrl[0][5:4] == 2'b00);
    c_dma: cover property (chanDmaReq[1]);
    c_break_clear: cover property (debugBreak && breakClearEnable && $fell(s.overflow_flag));
endmodule
`default_nettype wire

// ==== src/mcc_consts.svh ====
// register indices, field positions, reset values of the modulo counter core
`ifndef MCC_CONSTS_SVH
`define MCC_CONSTS_SVH
// register indices; the apb byte address is four times the index
`define IDX_STATUS    8'h20
`define IDX_ROUTE     8'h21
`define IDX_CNT_HI    8'h22
`define IDX_CNT_LO    8'h23
`define IDX_PER_HI    8'h24
`define IDX_PER_LO    8'h25
`define IDX_CH0_CTRL  8'h26
`define IDX_CH1_CTRL  8'h29
`define IDX_CH2_CTRL  8'h2C
`define IDX_CH3_CTRL  8'h2F
`define IDX_CH0_HI    8'h27
`define IDX_CH1_HI    8'h2A
`define IDX_CH2_HI    8'h2D
`define IDX_CH3_HI    8'h30
// main status fields
`define ST_FLAG       7
`define ST_IRQ_EN     6
`define ST_HALT       5
`define ST_CLEAR      4
`define STATUS_RESET  8'h20
`define PERIOD_RESET  16'hFFFF
`define SEL_EXTERNAL  3'h7
// channel control fields
`define CH_FLAG       7
`define CH_IE         6
`define CH_BUF        5
`define CH_MODE       4
`define CH_TOV        1
`define CH_MAX        0
`endif

// ==== src/mcc_pkg.sv ====
// state types of the modulo counter core
package mcc_pkg;
    typedef struct packed {
        logic [15:0]      count;       // counter value
        logic [15:0]      period;      // wrap point
        logic             perInhibit;  // high period byte written, low pending
        logic             overflow_flag;         // overflow flag
        logic             tofArm;      // flag seen set by a status read
        logic             overflow_irq_enable;        // overflow interrupt enable
        logic             halt;        // counter halt
        logic [2:0]       divSel;      // clock divide select
        logic [3:0]       route;       // per channel request route
        logic [7:0]       lowLatch;    // latched low count byte
        logic             latched;     // low byte held
        logic             step;        // counter moved last cycle
        logic             wrapped;     // counter wrapped last cycle
        logic [3:0][7:0]  chCtrl;      // channel control bytes
        logic [3:0][15:0] chVal;       // channel capture/compare values
        logic [3:0]       chArm;       // channel flag seen set by a read
        logic [3:0]       chHiRead;    // value high byte read, low pending
    } core_state_t;
    typedef struct packed {
        logic [2:0] sync;  // pin synchroniser
        logic [5:0] div;   // prescaler
    } presc_state_t;
    typedef struct packed {
        logic [2:0] sync;  // pin synchroniser
        logic       level; // driven pin level
    } chan_state_t;
endpackage

// ==== src/count_prescaler.sv ====
// prescaler and external count clock qualifier
`timescale 1ns/100ps
`default_nettype none
module count_prescaler
    import mcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       run,       // counting allowed
    input  wire logic       clear,     // zero the prescaler
    input  wire logic [2:0] divSel,    // divide select
    input  wire logic       extPin,    // external count clock pin
    output logic            tick       // one-cycle counter enable
);
`include "mcc_consts.svh"
    presc_state_t s;
    presc_state_t next_s;
    logic [5:0]   mask;

    // low bits that must all be set for a divided tick
    function automatic logic [5:0] divMask(input logic [2:0] sel);
        divMask = 6'((7'h01 << sel) - 7'h01);
    endfunction

    // pin sync and prescaler; the first sync stage feeds only the second
    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[1:0], extPin};
        mask = divMask(divSel);
        if (clear) begin
            next_s.div = 6'h00;
        end else if (run) begin
            next_s.div = s.div + 6'h01;
        end
        if (clear || !run) begin
            tick = 1'b0;
        end else if (divSel == `SEL_EXTERNAL) begin
            tick = s.sync[1] && !s.sync[2];
        end else begin
            tick = (s.div & mask) == mask;
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ==== src/capture_compare_channel.sv ====
// one capture/compare channel: edge detect, match action, pin drive
`timescale 1ns/100ps
`default_nettype none
module capture_compare_channel
    import mcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [7:0] ctrl,      // channel control byte
    input  wire logic       enable,    // channel not taken by a linked pair
    input  wire logic       match,     // counter just reached the value
    input  wire logic       wrap,      // counter just wrapped
    input  wire logic       hold,      // value high byte read, low pending
    input  wire logic       pinIn,     // channel pin level
    output logic            event_,    // capture or compare event
    output logic            pinOut,    // driven level
    output logic            pinOeN     // low while driving
);
`include "mcc_consts.svh"
    chan_state_t s;
    chan_state_t next_s;
    logic [1:0]  els;
    logic        rise;
    logic        fall;
    logic        capMode;
    logic        cmpMode;
    logic        cmpEvt;

    // decode mode and qualify pin edges
    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[1:0], pinIn};
        els = ctrl[3:2];
        rise = s.sync[1] && !s.sync[2];
        fall = !s.sync[1] && s.sync[2];
        capMode = enable && (ctrl[5:4] == 2'b00) && (els != 2'b00);
        cmpMode = enable && (ctrl[5:4] != 2'b00) && (els != 2'b00);
        cmpEvt = cmpMode && match;
        event_ = cmpEvt || (capMode && ((els[0] && rise) || (els[1] && fall)));
        if (els == 2'b00) begin
            // preset level while under port control
            next_s.level = !ctrl[`CH_MODE];
        end else if (cmpMode) begin
            if (ctrl[`CH_MAX] && !ctrl[`CH_TOV]) begin
                // full duty holds the pulse level
                next_s.level = (els != 2'b11);
            end else if (wrap && ctrl[`CH_TOV]) begin
                // overflow toggle beats a same-cycle compare
                next_s.level = hold ? s.level : !s.level;
            end else if (cmpEvt) begin
                case (els)
                    2'b01: next_s.level = hold ? s.level : !s.level;
                    2'b10: next_s.level = 1'b0;
                    2'b11: next_s.level = 1'b1;
                    default: next_s.level = s.level;
                endcase
            end
        end
        pinOut = s.level;
        pinOeN = !cmpMode;
    end

    // state register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the modulo counter core
`timescale 1ns/100ps
`default_nettype none
`include "mcc_consts.svh"
module tb;
    logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;                                  // byte address
    logic [31:0] pwdata, prdata;
    logic        debugBreak, breakClearEnable, extCountClock, extClockInUse, overflowIrq;
    logic [3:0]  chanPinIn, chanPinOut, chanPinOeN, chanIrq, chanDmaReq;
    int          errorCnt = 0;                           // mismatches seen
    int          nTests   = 0;                           // comparisons made
    logic [32:0] expQ[$], maskQ[$];                      // expected {slverr, data} and mask
    string       nameQ[$];                               // what each note checks
    logic [7:0]  rnd;                                    // random route pattern
    int          w;                                      // divider window in cycles

    modulo_counter_capture_compare_core u_dut (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debugBreak(debugBreak),
        .breakClearEnable(breakClearEnable), .extCountClock(extCountClock),
        .extClockInUse(extClockInUse), .chanPinIn(chanPinIn), .chanPinOut(chanPinOut),
        .chanPinOeN(chanPinOeN), .overflowIrq(overflowIrq), .chanIrq(chanIrq),
        .chanDmaReq(chanDmaReq));

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // compare and count; unknowns never match
    task automatic check(input string nm, input logic [32:0] exp, input logic [32:0] got);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer: setup, then access held until pready is seen high
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] data);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, data};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // read with a note of the expected answer for the watcher
    task automatic rd(input logic [7:0] idx, input logic [32:0] exp, input string nm,
                      input logic [32:0] mask = 33'h1_FFFF_FFFF);
        expQ.push_back(exp);
        maskQ.push_back(mask);
        nameQ.push_back(nm);
        apb(idx, 1'b0, 8'h00);
    endtask

    // external count pin pulse, each level well over two bus cycles
    task automatic pulse();
        repeat (4) @(posedge sys_clk);
        extCountClock <= 1'b1;
        repeat (4) @(posedge sys_clk);
        extCountClock <= 1'b0;
    endtask

    task automatic printVerdict();
        if (errorCnt == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watcher: every completed read is matched against the oldest note
    always @(posedge sys_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0) begin
            check(nameQ.pop_front(), expQ.pop_front(), {pslverr, prdata} & maskQ.pop_front());
        end
    end

    // watchdog: the whole run is under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        errorCnt++;
        printVerdict();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {debugBreak, breakClearEnable, extCountClock, chanPinIn} = '0;
        void'($urandom(60));
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        // reset values
        rd(`IDX_STATUS, 33'h20, "status");
        rd(`IDX_ROUTE, 33'h0, "route");
        rd(`IDX_PER_HI, 33'hFF, "period high");
        rd(`IDX_PER_LO, 33'hFF, "period low");
        rd(`IDX_CH0_CTRL, 33'h0, "chan0 control");
        rd(8'h3F, 33'h1_0000_0000, "unmapped");
        rnd = 8'($urandom() & 32'hF);
        apb(`IDX_ROUTE, 1'b1, rnd);
        rd(`IDX_ROUTE, {25'h0, rnd}, "route random");
        apb(`IDX_CH1_CTRL, 1'b1, 8'h20);
        rd(`IDX_CH1_CTRL, 33'h0, "chan1 buffered");
        // short period, counter cleared and halted together
        apb(`IDX_STATUS, 1'b1, 8'h30);
        apb(`IDX_PER_HI, 1'b1, 8'h00);
        apb(`IDX_PER_LO, 1'b1, 8'h03);
        rd(`IDX_CNT_HI, 33'h0, "count high");
        rd(`IDX_CNT_LO, 33'h0, "count low");
        rd(`IDX_STATUS, 33'h20, "clear reads zero");
        // run past the wrap point, then halt
        apb(`IDX_STATUS, 1'b1, 8'h00);
        repeat (12) @(posedge sys_clk);
        apb(`IDX_STATUS, 1'b1, 8'h20);
        // write 0 without a prior read must not clear the flag
        apb(`IDX_STATUS, 1'b1, 8'h60);
        @(negedge sys_clk);
        check("overflow irq", 33'h1, {32'h0, overflowIrq});
        rd(`IDX_STATUS, 33'hE0, "flag kept");
        apb(`IDX_STATUS, 1'b1, 8'h60);
        @(negedge sys_clk);
        check("overflow irq off", 33'h0, {32'h0, overflowIrq});
        rd(`IDX_STATUS, 33'h60, "flag cleared");
        // a clear armed before a protected break only finishes after it
        apb(`IDX_STATUS, 1'b1, 8'h40);
        repeat (8) @(posedge sys_clk);
        apb(`IDX_STATUS, 1'b1, 8'h60);
        rd(`IDX_STATUS, 33'hE0, "flag set");
        debugBreak <= 1'b1;
        apb(`IDX_STATUS, 1'b1, 8'h60);
        rd(`IDX_STATUS, 33'hE0, "flag kept in break");
        debugBreak <= 1'b0;
        apb(`IDX_STATUS, 1'b1, 8'h60);
        rd(`IDX_STATUS, 33'h60, "flag cleared after break");
        // with break clears enabled a clear in break sticks
        apb(`IDX_STATUS, 1'b1, 8'h40);
        repeat (8) @(posedge sys_clk);
        apb(`IDX_STATUS, 1'b1, 8'h60);
        {debugBreak, breakClearEnable} <= 2'b11;
        rd(`IDX_STATUS, 33'hE0, "flag in break");
        apb(`IDX_STATUS, 1'b1, 8'h60);
        {debugBreak, breakClearEnable} <= 2'b00;
        rd(`IDX_STATUS, 33'h60, "flag after break");
        // external pin counts, break freezes it, high read latches low
        apb(`IDX_STATUS, 1'b1, 8'h37);
        apb(`IDX_STATUS, 1'b1, 8'h07);
        @(negedge sys_clk);
        check("ext pin in use", 33'h1, {32'h0, extClockInUse});
        pulse();
        pulse();
        debugBreak <= 1'b1;
        pulse();
        debugBreak <= 1'b0;
        rd(`IDX_CNT_HI, 33'h0, "count high ext");
        pulse();
        rd(`IDX_CNT_LO, 33'h2, "latched low");
        rd(`IDX_CNT_LO, 33'h3, "live low");
        // every internal divider over a window of eight and a half periods, rounded down to whole cycles
        apb(`IDX_STATUS, 1'b1, 8'h37);
        apb(`IDX_PER_HI, 1'b1, 8'hFF);
        apb(`IDX_PER_LO, 1'b1, 8'hFF);
        for (int n = 0; n < 7; n++) begin
            w = (8 << n) + ((1 << n) >> 1);
            apb(`IDX_STATUS, 1'b1, 8'h30 | 8'(n));
            apb(`IDX_STATUS, 1'b1, 8'(n));
            repeat (w - 3) @(posedge sys_clk);
            apb(`IDX_STATUS, 1'b1, 8'h20 | 8'(n));
            rd(`IDX_CNT_HI, 33'h0, "div count high");
            rd(`IDX_CNT_LO, 33'h8, "div count low", 33'h1_FFFF_FFFE);
        end
        // rising edge capture on channel 0, routed to cpu then dma
        apb(`IDX_ROUTE, 1'b1, 8'h00);
        apb(`IDX_CH0_CTRL, 1'b1, 8'h44);
        chanPinIn[0] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        check("chan irq", 33'h1, {32'h0, chanIrq[0]});
        check("chan dma", 33'h0, {32'h0, chanDmaReq[0]});
        apb(`IDX_ROUTE, 1'b1, 8'h01);
        @(negedge sys_clk);
        check("chan dma on", 33'h1, {32'h0, chanDmaReq[0]});
        check("chan irq off", 33'h0, {32'h0, chanIrq[0]});
        rd(`IDX_CH0_HI + 8'h01, 33'h8, "capture low");
        @(negedge sys_clk);
        check("chan dma cleared", 33'h0, {32'h0, chanDmaReq[0]});
        apb(`IDX_CH2_CTRL, 1'b1, 8'h1C);
        @(negedge sys_clk);
        check("chan pin oe", 33'hB, {29'h0, chanPinOeN});
        check("chan2 level", 33'h1, {32'h0, chanPinOut[2]});
        repeat (4) @(posedge sys_clk);
        printVerdict();
    end
endmodule
`default_nettype wire
